// file: hw/adc_transfer_irq_regs.sv
// Behaviour
// - sync one-two cycles, write, then wait
// - transfer done in 3, or 4 low-power
// - clock runs, processor stopped: stay asleep
// - clock stopped: restart from dco briefly
// - channel 1010 routes temperature sensor
// - temperature channel forces reference generator only
// - count zero: flag per new result
// - count nonzero: flag at block end
// - request when flag, enable, global set
// - flag clears on service or write
// - transfer controls at 048h, 049h, cleared
// - start address at 01BCh, resets 0200h
// - control0 01B0h, control1 01B2h, result 01B4h
// - locked fields ignore writes while enabled
// - sample-time code gives 4/8/16/64 clocks
// - reference select bits 15-13
// - bit 10 selects buffer drive rate
// - bit 9 ref output, bit 8 burst
// - nonzero count enables transfer per result
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "conv_ctrl_consts.svh"
`default_nettype none

module adc_transfer_irq_regs #(
    parameter int DCO_START_CYCLES = `DCO_START_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // avalon-mm slave
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [1:0] avs_byteenable_i,
    input wire logic [15:0] avs_writedata_i,
    output logic [15:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // converter core
    input wire logic result_load_i,
    input wire logic [15:0] result_data_i,
    // processor and clock system
    input wire logic global_irq_enable_i,
    input wire logic irq_ack_i,
    input wire logic cpu_off_i,
    input wire logic sysclk_off_i,
    input wire logic dco_ready_i,
    // memory write port of the transfer controller
    output logic mem_write_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    output logic cpu_hold_o,
    output logic sysclk_request_o,
    output logic xfer_done_o,
    // converter configuration
    output logic [3:0] channel_select_o,
    output logic temp_sensor_sel_o,
    output logic reference_on_o,
    output logic reference_output_enable_o,
    output logic reference_burst_mode_o,
    output logic [2:0] reference_select_o,
    output logic buffer_rate_select_o,
    output logic [7:0] sample_clocks_o,
    output logic conversion_enable_o,
    output logic start_conv_o,
    output logic [7:0] analog_input_enable_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    // both flops clear together; the logic leaves reset two edges after release
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    // one packed copy keeps every register but the reset and derived-output flops in a single next-state process
    typedef struct packed {
        logic [15:0] ctl0;
        logic [15:0] ctl1;
        logic [15:0] result;
        logic [15:0] start_addr;
        logic [7:0] xctl0;
        logic [7:0] xcount;
        logic [7:0] ain_en;
        conv_ctrl_pkg::xfer_state_t xs;
        logic [1:0] sync_cnt;
        logic [15:0] dco_cnt;
        logic [15:0] ptr;
        logic [7:0] remain;
        logic armed;
        logic pending;
        logic [15:0] rdata;
        logic wait_req;
        logic [1:0] resp;
        logic mem_wr;
        logic [15:0] mem_addr;
        logic [15:0] mem_data;
        logic hold;
        logic clk_req;
        logic done;
        logic irq;
        logic [7:0] sample_clks;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    logic acc;
    logic [15:0] wr_hi;
    logic [15:0] wr_mask;
    logic hit_ctl0;
    logic set_ifg;
    logic clr_ifg;
    logic mapped;
    logic [15:0] rd_val;

    assign acc = (avs_read_i | avs_write_i) & cur_ff.wait_req;
    assign wr_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign hit_ctl0 = avs_write_i & acc & (avs_address_i == `ADDR_CONV_CTL0);

    always_comb
    begin
        // unmapped offsets read zero and answer with a slave error
        mapped = 1'b1;
        case (avs_address_i)
            `ADDR_XFER_CTL0: rd_val = {8'h00, cur_ff.xctl0};
            `ADDR_XFER_COUNT: rd_val = {8'h00, cur_ff.xcount};
            `ADDR_AIN_EN: rd_val = {8'h00, cur_ff.ain_en};
            `ADDR_CONV_CTL0: rd_val = cur_ff.ctl0;
            `ADDR_CONV_CTL1: rd_val = cur_ff.ctl1;
            `ADDR_CONV_RESULT: rd_val = cur_ff.result;
            `ADDR_XFER_START: rd_val = cur_ff.start_addr;
            `ADDR_SYS_CTRL: rd_val = {14'h0000, cur_ff.armed, cur_ff.xs != conv_ctrl_pkg::XS_IDLE};
            default:
            begin
                rd_val = 16'h0000;
                mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        wr_hi = 16'h0000;
        set_ifg = 1'b0;
        clr_ifg = 1'b0;
        nxt_cur.mem_wr = 1'b0;
        nxt_cur.done = 1'b0;

        // bus: one wait cycle, answer on the second cycle of the request
        nxt_cur.wait_req = ~acc;
        nxt_cur.resp = 2'h0;
        if (acc)
        begin
            nxt_cur.rdata = avs_read_i ? rd_val : 16'h0000;
            nxt_cur.resp = mapped ? 2'h0 : 2'h2;
        end

        // start bit is a one-cycle strobe
        nxt_cur.ctl0[`C0_SC] = 1'b0;

        if (avs_write_i && acc)
        begin
            case (avs_address_i)
                `ADDR_XFER_CTL0: if (avs_byteenable_i[0]) nxt_cur.xctl0 = avs_writedata_i[7:0] & `XC0_MASK;
                `ADDR_XFER_COUNT: if (avs_byteenable_i[0]) nxt_cur.xcount = avs_writedata_i[7:0];
                `ADDR_AIN_EN: if (avs_byteenable_i[0]) nxt_cur.ain_en = avs_writedata_i[7:0];
                `ADDR_CONV_CTL0:
                begin
                    // locked fields only while conversion is disabled
                    wr_hi = cur_ff.ctl0[`C0_ENC] ? (wr_mask & ~`C0_LOCK_MASK) : wr_mask;
                    nxt_cur.ctl0 = (cur_ff.ctl0 & ~wr_hi) | (avs_writedata_i & wr_hi);
                    clr_ifg = wr_hi[`C0_IFG] & ~avs_writedata_i[`C0_IFG];
                end
                `ADDR_CONV_CTL1:
                begin
                    wr_hi = cur_ff.ctl0[`C0_ENC] ? 16'h0000 : wr_mask;
                    nxt_cur.ctl1 = (cur_ff.ctl1 & ~wr_hi) | (avs_writedata_i & wr_hi);
                end
                `ADDR_XFER_START:
                begin
                    nxt_cur.start_addr = (cur_ff.start_addr & ~wr_mask) | (avs_writedata_i & wr_mask);
                    // re-arm the transfer controller on any start-address write made while the count is nonzero
                    nxt_cur.ptr = nxt_cur.start_addr;
                    nxt_cur.remain = cur_ff.xcount;
                    nxt_cur.armed = cur_ff.xcount != 8'h00;
                end
                default:
                begin
                end
            endcase
        end

        if (irq_ack_i && cur_ff.irq)
            clr_ifg = 1'b1;

        // new result
        if (result_load_i)
        begin
            nxt_cur.result = result_data_i;
            if (cur_ff.xcount == 8'h00)
                set_ifg = 1'b1;
            else if (cur_ff.armed)
                nxt_cur.pending = 1'b1;
        end

        // transfer controller: wake, sync, write with a running cpu held, wait
        case (cur_ff.xs)
            conv_ctrl_pkg::XS_IDLE:
            begin
                if (cur_ff.pending)
                begin
                    nxt_cur.pending = 1'b0;
                    nxt_cur.sync_cnt = `SYNC_CYCLES;
                    if (sysclk_off_i)
                    begin
                        // clock stopped: ask for a dco-sourced clock for this transfer only
                        nxt_cur.clk_req = 1'b1;
                        nxt_cur.dco_cnt = DCO_START_CYCLES[15:0];
                        nxt_cur.xs = conv_ctrl_pkg::XS_WAKE;
                    end
                    else
                        nxt_cur.xs = conv_ctrl_pkg::XS_SYNC;
                end
            end
            conv_ctrl_pkg::XS_WAKE:
            begin
                // wait out the start-up time, then for the oscillator itself
                if (cur_ff.dco_cnt != 16'h0000)
                    nxt_cur.dco_cnt = cur_ff.dco_cnt - 16'h0001;
                else if (dco_ready_i)
                    nxt_cur.xs = conv_ctrl_pkg::XS_SYNC;
            end
            conv_ctrl_pkg::XS_SYNC:
            begin
                // a sleeping processor costs one extra sync cycle
                if (cur_ff.sync_cnt != 2'h0 && cpu_off_i)
                    nxt_cur.sync_cnt = cur_ff.sync_cnt - 2'h1;
                else
                begin
                    nxt_cur.xs = conv_ctrl_pkg::XS_WRITE;
                    nxt_cur.hold = ~cpu_off_i;
                    nxt_cur.mem_wr = 1'b1;
                    nxt_cur.mem_addr = cur_ff.ptr;
                    nxt_cur.mem_data = cur_ff.result;
                end
            end
            conv_ctrl_pkg::XS_WRITE:
            begin
                // pointer and count step only once the word is on the bus
                nxt_cur.hold = 1'b0;
                nxt_cur.ptr = cur_ff.ptr + 16'h0002;
                nxt_cur.remain = cur_ff.remain - 8'h01;
                nxt_cur.xs = conv_ctrl_pkg::XS_WAIT;
            end
            conv_ctrl_pkg::XS_WAIT:
            begin
                // dropping the request here lets a stopped clock stop again
                nxt_cur.xs = conv_ctrl_pkg::XS_IDLE;
                nxt_cur.clk_req = 1'b0;
                nxt_cur.done = 1'b1;
                if (cur_ff.remain == 8'h00)
                begin
                    set_ifg = 1'b1;
                    nxt_cur.armed = 1'b0;
                end
            end
            default:
                nxt_cur.xs = conv_ctrl_pkg::XS_IDLE;
        endcase

        // hardware set wins over software or service clear
        if (set_ifg)
            nxt_cur.ctl0[`C0_IFG] = 1'b1;
        else if (clr_ifg)
            nxt_cur.ctl0[`C0_IFG] = 1'b0;
        else if (hit_ctl0 && wr_hi[`C0_IFG])
            nxt_cur.ctl0[`C0_IFG] = avs_writedata_i[`C0_IFG];

        nxt_cur.irq = nxt_cur.ctl0[`C0_IFG] & nxt_cur.ctl0[`C0_IE] & global_irq_enable_i;

        // decoded from the next value so the length follows a write at once
        case (nxt_cur.ctl0[`C0_SHT_HI:`C0_SHT_LO])
            2'h0: nxt_cur.sample_clks = `SHT_CLKS_0;
            2'h1: nxt_cur.sample_clks = `SHT_CLKS_1;
            2'h2: nxt_cur.sample_clks = `SHT_CLKS_2;
            default: nxt_cur.sample_clks = `SHT_CLKS_3;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            cur_ff <= '0;
            cur_ff.ctl0 <= `RST_CONV_CTL0;
            cur_ff.start_addr <= `RST_XFER_START;
            cur_ff.ptr <= `RST_XFER_START;
            cur_ff.xs <= conv_ctrl_pkg::XS_IDLE;
            cur_ff.wait_req <= 1'b1;
            cur_ff.sample_clks <= `SHT_CLKS_0;
        end
        else
            cur_ff <= nxt_cur;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // derived outputs get flops of their own so no output is a gate
    logic temp_ff;
    logic refon_ff;
    logic burst_ff;

    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            temp_ff <= 1'b0;
            refon_ff <= 1'b0;
            burst_ff <= 1'b0;
        end
        else
        begin
            temp_ff <= nxt_cur.ctl1[`C1_CH_HI:`C1_CH_LO] == `CH_TEMP;
            // temperature channel forces the generator but not its pin or selection
            refon_ff <= nxt_cur.ctl0[`C0_REFON] |
                (nxt_cur.ctl1[`C1_CH_HI:`C1_CH_LO] == `CH_TEMP);
            // burst only counts while the output itself is on
            burst_ff <= nxt_cur.ctl0[`C0_BURST] & nxt_cur.ctl0[`C0_REFERENCE_OUTPUT_ENABLE];
        end
    end

    assign avs_readdata_o = cur_ff.rdata;
    assign avs_waitrequest_o = cur_ff.wait_req;
    assign avs_response_o = cur_ff.resp;
    assign mem_write_o = cur_ff.mem_wr;
    assign mem_addr_o = cur_ff.mem_addr;
    assign mem_wdata_o = cur_ff.mem_data;
    assign cpu_hold_o = cur_ff.hold;
    assign sysclk_request_o = cur_ff.clk_req;
    assign xfer_done_o = cur_ff.done;
    assign channel_select_o = cur_ff.ctl1[`C1_CH_HI:`C1_CH_LO];
    assign temp_sensor_sel_o = temp_ff;
    assign reference_on_o = refon_ff;
    assign reference_output_enable_o = cur_ff.ctl0[`C0_REFERENCE_OUTPUT_ENABLE];
    assign reference_burst_mode_o = burst_ff;
    assign reference_select_o = cur_ff.ctl0[`C0_REFSEL_HI:`C0_REFSEL_LO];
    assign buffer_rate_select_o = cur_ff.ctl0[`C0_RATE];
    assign sample_clocks_o = cur_ff.sample_clks;
    assign conversion_enable_o = cur_ff.ctl0[`C0_ENC];
    assign start_conv_o = cur_ff.ctl0[`C0_SC];
    assign analog_input_enable_o = cur_ff.ain_en;
    assign irq_o = cur_ff.irq;

endmodule : adc_transfer_irq_regs

`default_nettype wire

// file: hw/conv_ctrl_consts.svh
`ifndef CONV_CTRL_CONSTS_SVH
`define CONV_CTRL_CONSTS_SVH

// byte addresses on the register bus
`define ADDR_XFER_CTL0 16'h0048
`define ADDR_XFER_COUNT 16'h0049
`define ADDR_AIN_EN 16'h004A
`define ADDR_CONV_CTL0 16'h01B0
`define ADDR_CONV_CTL1 16'h01B2
`define ADDR_CONV_RESULT 16'h01B4
`define ADDR_XFER_START 16'h01BC
`define ADDR_SYS_CTRL 16'h01C0

// reset values
`define RST_CONV_CTL0 16'h0000
`define RST_XFER_START 16'h0200

// converter_control_0 fields
`define C0_REFSEL_HI 15
`define C0_REFSEL_LO 13
`define C0_SHT_HI 12
`define C0_SHT_LO 11
`define C0_RATE 10
`define C0_REFERENCE_OUTPUT_ENABLE 9
`define C0_BURST 8
`define C0_REFON 5
`define C0_IE 3
`define C0_IFG 2
`define C0_ENC 1
`define C0_SC 0
// bits that may only change while conversion_enable is low
`define C0_LOCK_MASK 16'hFFF0

// converter_control_1 channel field
`define C1_CH_HI 15
`define C1_CH_LO 12
`define CH_TEMP 4'hA

// transfer_control_0 writable bits
`define XC0_MASK 8'h0F

// sample-time lengths in conversion clocks
`define SHT_CLKS_0 8'h04
`define SHT_CLKS_1 8'h08
`define SHT_CLKS_2 8'h10
`define SHT_CLKS_3 8'h40

// transfer timing in system-clock cycles, start-up time and clock period in ns
`define SYNC_CYCLES 2'h1
`define DCO_START_NS 6000
`define CLK_PERIOD_NS 5
`define DCO_START_CYCLES ((`DCO_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hw/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    typedef enum logic [2:0] {
        XS_IDLE,
        XS_WAKE,
        XS_SYNC,
        XS_WRITE,
        XS_WAIT
    } xfer_state_t;

endpackage : conv_ctrl_pkg

// file: bench/adc_transfer_irq_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.svh"

module adc_transfer_irq_regs_props (
    // watched ports of the register block
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic result_load_i,
    input wire logic global_irq_enable_i,
    input wire logic irq_ack_i,
    input wire logic cpu_off_i,
    input wire logic sysclk_off_i,
    input wire logic mem_write_o,
    input wire logic cpu_hold_o,
    input wire logic sysclk_request_o,
    input wire logic xfer_done_o,
    input wire logic [3:0] channel_select_o,
    input wire logic temp_sensor_sel_o,
    input wire logic reference_on_o,
    input wire logic reference_output_enable_o,
    input wire logic reference_burst_mode_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////////////////////
    property p_answer_next; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o; endproperty
    a_answer_next: assert property (p_answer_next)
        else $error("bus request not answered one cycle later");
    property p_answer_short; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_answer_short: assert property (p_answer_short)
        else $error("waitrequest low for more than one cycle");
    property p_hold_active; mem_write_o && !cpu_off_i |-> cpu_hold_o; endproperty
    a_hold_active: assert property (p_hold_active)
        else $error("processor not held during transfer write");
    property p_no_wake; mem_write_o && cpu_off_i |-> !cpu_hold_o; endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("stopped processor touched by transfer");
    property p_clk_up; mem_write_o && sysclk_off_i |-> sysclk_request_o; endproperty
    a_clk_up: assert property (p_clk_up)
        else $error("transfer without restarted system clock");
    property p_done_late; xfer_done_o |-> $past(mem_write_o) || $past(mem_write_o, 2); endproperty
    a_done_late: assert property (p_done_late)
        else $error("transfer end not shortly after its write");
    property p_temp; channel_select_o == `CH_TEMP |-> temp_sensor_sel_o && reference_on_o; endproperty
    a_temp: assert property (p_temp)
        else $error("temperature channel without sensor and reference");
    property p_burst; reference_burst_mode_o |-> reference_output_enable_o; endproperty
    a_burst: assert property (p_burst)
        else $error("burst without reference output");
    property p_gie; !global_irq_enable_i |=> !irq_o; endproperty
    a_gie: assert property (p_gie)
        else $error("request raised with global enable low");
    property p_ack_drop; irq_ack_i && !result_load_i ##1 !result_load_i |=> !irq_o; endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request still up after service");

    c_lowpower: cover property (mem_write_o && sysclk_off_i);
    c_serviced: cover property ($fell(irq_o));
    c_temp: cover property (temp_sensor_sel_o);
endmodule : adc_transfer_irq_regs_props

`default_nettype wire

// file: bench/mem_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_bus_model (
    // clock
    input wire logic clk_i,
    // transfer controller side
    input wire logic mem_write_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic sysclk_request_i,
    output logic dco_ready_o,
    // interrupt side
    input wire logic irq_i,
    input wire logic ack_en_i,
    output logic irq_ack_o
);
    logic [15:0] mem [0:255];
    logic [1:0] dco_cnt = 2'h0;
    logic [2:0] gap = 3'h0;

    always @(posedge clk_i)
    begin
        if (mem_write_i)
            mem[mem_addr_i[8:1]] <= mem_wdata_i;
        // oscillator settles a few cycles after each request, off otherwise
        dco_cnt <= !sysclk_request_i ? 2'h0 : (dco_cnt == 2'h3 ? dco_cnt : dco_cnt + 2'h1);
        // service once, then stay away until the request had time to drop
        gap <= (gap != 3'h0) ? gap - 3'h1 : ((irq_i && ack_en_i) ? 3'h4 : 3'h0);
    end
    assign dco_ready_o = (dco_cnt == 2'h3);
    assign irq_ack_o = (gap == 3'h4);
endmodule : mem_bus_model

`default_nettype wire

// file: bench/test_adc_transfer_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_adc_transfer_irq_regs;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] avs_address_i = 16'h0000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [1:0] avs_byteenable_i = 2'h3;
    logic [15:0] avs_writedata_i = 16'h0000;
    logic result_load_i = 1'b0;
    logic [15:0] result_data_i = 16'h0000;
    logic global_irq_enable_i = 1'b0;
    logic cpu_off_i = 1'b0;
    logic sysclk_off_i = 1'b0;
    logic ack_en = 1'b0;
    logic irq_ack_i, dco_ready_i, avs_waitrequest_o, mem_write_o, sysclk_request_o, xfer_done_o;
    logic irq_o, temp_sensor_sel_o, reference_on_o, reference_output_enable_o;
    logic reference_burst_mode_o, buffer_rate_select_o, conversion_enable_o, start_conv_o;
    logic [15:0] avs_readdata_o, mem_addr_o, mem_wdata_o, v;
    logic [1:0] avs_response_o;
    logic [3:0] channel_select_o;
    logic [2:0] reference_select_o;
    logic [7:0] sample_clocks_o, analog_input_enable_o;
    logic [7:0] sht_tab [4] = '{8'h04, 8'h08, 8'h10, 8'h40};
    // one cycle of slack for the registered load strobe; deep sleep adds the restart;
    // the done pulse is seen one edge after the edge that launches it
    int lims [3] = '{4, 5, 13};
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    logic [31:0] seed = 32'hB10C;
    logic [31:0] xq [$];
    logic [33:0] rq [$];

    adc_transfer_irq_regs #(.DCO_START_CYCLES(4)) adc_transfer_irq_regs_i (.clk_i, .nrst_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .result_load_i, .result_data_i,
        .global_irq_enable_i, .irq_ack_i, .cpu_off_i, .sysclk_off_i, .dco_ready_i, .mem_write_o,
        .mem_addr_o, .mem_wdata_o, .cpu_hold_o(), .sysclk_request_o, .xfer_done_o,
        .channel_select_o, .temp_sensor_sel_o, .reference_on_o, .reference_output_enable_o,
        .reference_burst_mode_o, .reference_select_o, .buffer_rate_select_o, .sample_clocks_o,
        .conversion_enable_o, .start_conv_o, .analog_input_enable_o, .irq_o);

    mem_bus_model mem_bus_model_i (.clk_i, .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .sysclk_request_i(sysclk_request_o), .dco_ready_o(dco_ready_i),
        .irq_i(irq_o), .ack_en_i(ack_en), .irq_ack_o(irq_ack_i));

    initial forever #2.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        // byte-wide registers sit on lane 0
        avs_byteenable_i <= (a < 16'h0100) ? 2'h1 : 2'h3;
        avs_read_i <= !w;
        avs_write_i <= w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m,
                      input logic [1:0] r);
        rq.push_back({r, m, e});
        bus(1'b0, a, 16'h0000);
    endtask : rd

    task automatic load(input logic [15:0] d);
        @(posedge clk_i);
        result_load_i <= 1'b1;
        result_data_i <= d;
        @(posedge clk_i);
        result_load_i <= 1'b0;
    endtask : load

    task automatic wait_irq(input logic lvl);
        int k = 0;
        while (irq_o !== lvl && k < 20)
        begin
            @(posedge clk_i);
            k++;
        end
        chk(irq_o, lvl);
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            close_out();
        end
    end

    always @(posedge clk_i)
    begin
        logic [33:0] nt;
        if (avs_read_i && avs_waitrequest_o === 1'b0)
        begin
            nt = rq.pop_front();
            chk(avs_readdata_o & nt[31:16], nt[15:0] & nt[31:16]);
            chk(avs_response_o, nt[33:32]);
        end
        if (mem_write_o === 1'b1)
            chk({mem_addr_o, mem_wdata_o}, xq.size() != 0 ? xq.pop_front() : 32'hX);
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(16'h01B0, 16'h0000, 16'hFFFF, 2'h0);
        rd(16'h01BC, 16'h0200, 16'hFFFF, 2'h0);
        rd(16'h0048, 16'h0000, 16'h00FF, 2'h0);
        rd(16'h0049, 16'h0000, 16'h00FF, 2'h0);
        rd(16'h004A, 16'h0000, 16'h00FF, 2'h0);
        rd(16'h0100, 16'h0000, 16'h0000, 2'h2);
        bus(1'b1, 16'h0048, 16'h00FF);
        rd(16'h0048, 16'h000F, 16'h00FF, 2'h0);
        bus(1'b1, 16'h0048, 16'h0000);
        seed = xs(seed);
        v = {8'h00, seed[7:0]};
        bus(1'b1, 16'h004A, v);
        rd(16'h004A, v, 16'h00FF, 2'h0);
        chk(analog_input_enable_o, v[7:0]);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            v = {seed[15:13], i[1:0], seed[10:6], 6'h00};
            bus(1'b1, 16'h01B0, v);
            rd(16'h01B0, v, 16'hFFFF, 2'h0);
            chk(reference_select_o, v[15:13]);
            chk(sample_clocks_o, sht_tab[i]);
            chk({buffer_rate_select_o, reference_output_enable_o, reference_burst_mode_o},
                {v[10], v[9], v[9] & v[8]});
        end
        // enabled converter: configuration must survive the writes below
        bus(1'b1, 16'h01B0, v | 16'h0003);
        chk(start_conv_o, 1'b1);
        bus(1'b1, 16'h01B0, 16'h0002);
        rd(16'h01B0, v | 16'h0002, 16'hFFFF, 2'h0);
        chk({conversion_enable_o, start_conv_o}, 2'h2);
        bus(1'b1, 16'h01B2, 16'hA000);
        rd(16'h01B2, 16'h0000, 16'hFFFF, 2'h0);
        bus(1'b1, 16'h01B0, 16'h0000);
        rd(16'h01B0, v, 16'hFFFF, 2'h0);
        bus(1'b1, 16'h01B2, 16'hA000);
        rd(16'h01B2, 16'hA000, 16'hFFFF, 2'h0);
        chk({channel_select_o, temp_sensor_sel_o, reference_on_o, reference_output_enable_o,
             reference_select_o}, {4'hA, 2'h3, v[9], v[15:13]});
        bus(1'b1, 16'h01B2, 16'h3000);
        rd(16'h01B2, 16'h3000, 16'hFFFF, 2'h0);
        chk({channel_select_o, temp_sensor_sel_o, reference_on_o}, {4'h3, 2'h0});
        bus(1'b1, 16'h01B0, 16'h0008);
        global_irq_enable_i <= 1'b1;
        ack_en <= 1'b1;
        load(16'h0155);
        wait_irq(1'b1);
        wait_irq(1'b0);
        rd(16'h01B0, 16'h0008, 16'h000C, 2'h0);
        ack_en <= 1'b0;
        load(16'h02AA);
        wait_irq(1'b1);
        bus(1'b1, 16'h01B0, 16'h0008);
        wait_irq(1'b0);
        global_irq_enable_i <= 1'b0;
        load(16'h0033);
        rd(16'h01B0, 16'h000C, 16'h000C, 2'h0);
        chk(irq_o, 1'b0);
        bus(1'b1, 16'h01B0, 16'h0000);
        bus(1'b1, 16'h0049, 16'h0003);
        bus(1'b1, 16'h01BC, 16'h0300);
        rd(16'h01C0, 16'h0002, 16'h0003, 2'h0);
        for (int i = 0; i < 3; i++)
        begin
            cpu_off_i <= (i != 0);
            sysclk_off_i <= (i == 2);
            seed = xs(seed);
            xq.push_back({16'h0300 + 16'(i * 2), seed[15:0]});
            load(seed[15:0]);
            n = 0;
            while (xfer_done_o !== 1'b1 && n < 40)
            begin
                @(posedge clk_i);
                n++;
            end
            chk(n - 1 <= lims[i], 1'b1);
            rd(16'h01B0, (i == 2) ? 16'h0004 : 16'h0000, 16'h0004, 2'h0);
        end
        cpu_off_i <= 1'b0;
        sysclk_off_i <= 1'b0;
        rd(16'h01B4, seed[15:0], 16'hFFFF, 2'h0);
        load(16'h0123);
        rd(16'h0049, 16'h0003, 16'h00FF, 2'h0);
        rd(16'h01C0, 16'h0000, 16'h0003, 2'h0);
        chk(xq.size(), 32'h0);
        close_out();
    end
endmodule : test_adc_transfer_irq_regs

bind adc_transfer_irq_regs adc_transfer_irq_regs_props props_i (.clk_i, .nrst_i, .avs_read_i,
    .avs_write_i, .avs_waitrequest_o, .result_load_i, .global_irq_enable_i, .irq_ack_i,
    .cpu_off_i, .sysclk_off_i, .mem_write_o, .cpu_hold_o, .sysclk_request_o, .xfer_done_o,
    .channel_select_o, .temp_sensor_sel_o, .reference_on_o, .reference_output_enable_o,
    .reference_burst_mode_o, .irq_o);

`default_nettype wire
